// ==== design/iwdt_map.svh ====
/*
 * Holds the address, code limits and timing figures of the I/O port watchdog.
 * Assumes it is included by bare name from the design modules iwdt_tick and iwdt_top.
 */
// Notes on behaviour
// RL1: A byte written to I/O port 0x443 is the interval code and starts counting.
// RL2: Codes 0x01 to 0x3E are accepted, one second per count.
// RL3: Each rewrite of the port restarts the countdown with the new code.
// RL4: A read of the port disables the watchdog and stops the countdown.
// RL5: At zero without refresh, pulse system reset, then stay off until rewritten.
`ifndef IWDT_MAP_SVH
`define IWDT_MAP_SVH

// ****************************************************************
// Port address and interval codes.
// ****************************************************************
`define IWDT_PORT_ADDR 16'h0443
`define IWDT_CODE_MIN 8'h01
`define IWDT_CODE_MAX 8'h3e
`define IWDT_COUNT_LAST 8'h01
`define IWDT_COUNT_OFF 8'h00

// ****************************************************************
// Timing.
// ****************************************************************
`define IWDT_CLK_PERIOD_NS 40
`define IWDT_SECOND_NS 1000000000
`define IWDT_RST_PULSE_NS 1000
`define IWDT_TICK_CYCLES (`IWDT_SECOND_NS / `IWDT_CLK_PERIOD_NS)
`define IWDT_RST_PULSE_CYCLES ((`IWDT_RST_PULSE_NS + `IWDT_CLK_PERIOD_NS - 1) / `IWDT_CLK_PERIOD_NS)

`endif

// ==== design/iwdt_pkg.sv ====
/*
 * Types shared by the watchdog modules.
 * Assumes iwdt_map.svh is on the include path.
 */
`default_nettype none
package iwdt_pkg;

   typedef enum logic [0:0] {
      IWDT_ST_OFF = 1'b0,
      IWDT_ST_RUN = 1'b1
   } iwdt_state_t;

   // One I/O bus cycle as seen by the block; strobes last one clock.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } iwdt_io_req_t;

   typedef struct packed {
      iwdt_state_t mode;
      logic [7:0] count;
      logic [7:0] pulse;
   } iwdt_regs_t;

endpackage
`default_nettype wire

// ==== design/iwdt_tick.sv ====
/*
 * One-second prescaler for the watchdog countdown.
 * Assumes restart_in and run_in come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "iwdt_map.svh"

module iwdt_tick #(
   parameter int unsigned TICK_CYCLES = `IWDT_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Control
   input wire logic restart_in,
   input wire logic run_in,
   // Second tick, one cycle wide
   output logic tick_out
);

   localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
   } iwdt_tick_regs_t;

   iwdt_tick_regs_t st;
   iwdt_tick_regs_t next_st;
   logic at_end;

   assign at_end = (st.cnt == CW'(TICK_CYCLES - 1));
   assign tick_out = run_in && !restart_in && at_end;

   // A restart clears the prescaler so a refreshed interval is a full second per count.
   always_comb begin
      next_st = st;
      if (restart_in || !run_in || at_end) begin
         next_st.cnt = '0;
      end else begin
         next_st.cnt = st.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // A restart or a stop must leave a full second before the next tick.
   AST_TICK_RESTART: assert property (@(posedge clk_in) disable iff (srst_in) // RL3
      restart_in |=> st.cnt == '0)
      else $error("prescaler did not clear on restart");

   AST_TICK_STEPS: assert property (@(posedge clk_in) disable iff (srst_in) // RL2
      run_in && !restart_in && !at_end |=> st.cnt == $past(st.cnt) + CW'(1))
      else $error("prescaler did not advance by one");

endmodule
`default_nettype wire

// ==== design/iwdt_top.sv ====
/*
 * Watchdog timer behind a single byte-wide I/O port.
 * Assumes the I/O bus strobes are synchronous to clk_in and one cycle wide.
 */
`timescale 1ns/100ps
`default_nettype none
`include "iwdt_map.svh"

module iwdt_top #(
   parameter int unsigned TICK_CYCLES = `IWDT_TICK_CYCLES,
   parameter int unsigned RST_PULSE_CYCLES = `IWDT_RST_PULSE_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // I/O port
   input wire iwdt_pkg::iwdt_io_req_t io_req_in,
   output logic [7:0] io_rdata_out,
   // Status and system reset
   output logic running_out,
   output logic sys_rst_out
);

   // ****************************************************************
   // State.
   // ****************************************************************
   iwdt_pkg::iwdt_regs_t st;
   iwdt_pkg::iwdt_regs_t next_st;
   logic hit_wr;
   logic hit_rd;
   logic code_ok;
   logic arm;
   logic tick;

   assign hit_wr = io_req_in.wr && (io_req_in.addr == `IWDT_PORT_ADDR);
   assign hit_rd = io_req_in.rd && (io_req_in.addr == `IWDT_PORT_ADDR);
   assign code_ok = (io_req_in.wdata >= `IWDT_CODE_MIN) && (io_req_in.wdata <= `IWDT_CODE_MAX);
   assign arm = hit_wr && code_ok && !hit_rd;

   iwdt_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .restart_in(arm || hit_rd),
      .run_in(st.mode == iwdt_pkg::IWDT_ST_RUN),
      .tick_out(tick)
   );

   // ****************************************************************
   // Countdown.
   // ****************************************************************
   // A read beats a write in the same cycle, so software can always turn the
   // watchdog off. Out-of-range codes are ignored rather than clipped.
   always_comb begin
      next_st = st;
      if (st.pulse != 8'h00) begin
         next_st.pulse = st.pulse - 8'h01;
      end
      if (hit_rd) begin
         next_st.mode = iwdt_pkg::IWDT_ST_OFF; // RL4
         next_st.count = `IWDT_COUNT_OFF;
      end else if (arm) begin
         next_st.mode = iwdt_pkg::IWDT_ST_RUN; // RL1
         next_st.count = io_req_in.wdata; // RL2 RL3
      end else begin
         case (st.mode)
            iwdt_pkg::IWDT_ST_RUN: begin
               if (tick) begin
                  if (st.count == `IWDT_COUNT_LAST) begin
                     next_st.mode = iwdt_pkg::IWDT_ST_OFF; // RL5
                     next_st.count = `IWDT_COUNT_OFF;
                     next_st.pulse = 8'(RST_PULSE_CYCLES);
                  end else begin
                     next_st.count = st.count - 8'h01;
                  end
               end
            end
            iwdt_pkg::IWDT_ST_OFF: begin
               next_st.count = `IWDT_COUNT_OFF;
            end
            default: begin
               next_st.mode = iwdt_pkg::IWDT_ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Read data is the seconds still to run; it reads zero while off.
   assign io_rdata_out = st.count;
   assign running_out = (st.mode == iwdt_pkg::IWDT_ST_RUN);
   assign sys_rst_out = (st.pulse != 8'h00);

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   // Expiry as the checks see it: the last second runs out with no access in the way.
   logic expiry;
   assign expiry = running_out && tick && (st.count == `IWDT_COUNT_LAST) && !hit_rd && !arm;

   AST_ARM_LOADS: assert property (arm |=> running_out && io_rdata_out == $past(io_req_in.wdata)) // RL1
      else $error("valid write did not arm with its code");

   AST_BAD_CODE_IGNORED: assert property (hit_wr && !code_ok && !hit_rd && !running_out |=> !running_out) // RL2
      else $error("out-of-range code armed the watchdog");

   AST_REFRESH_RESTARTS: assert property (running_out && arm // RL3
      |=> running_out && io_rdata_out == $past(io_req_in.wdata))
      else $error("refresh write did not restart the countdown");

   AST_READ_DISABLES: assert property (hit_rd |=> !running_out && io_rdata_out == 8'h00 ##1 !$rose(sys_rst_out)) // RL4
      else $error("read did not disable the watchdog");

   AST_EXPIRE_RESETS: assert property (running_out && tick && st.count == `IWDT_COUNT_LAST && !hit_rd && !arm // RL5
      |=> sys_rst_out && !running_out)
      else $error("expiry did not assert system reset");

   AST_STAYS_OFF: assert property (!running_out && !arm |=> !running_out) // RL5
      else $error("watchdog re-armed without a write");

   AST_COUNT_STEPS: assert property (running_out && tick && st.count > `IWDT_COUNT_LAST && !hit_rd && !arm // RL2
      |=> io_rdata_out == $past(st.count) - 8'h01)
      else $error("countdown did not step by one per second");

   AST_COUNT_HOLDS: assert property (running_out && !tick && !arm && !hit_rd // RL2
      |=> running_out && io_rdata_out == $past(st.count))
      else $error("count moved without a second tick");

   AST_RUN_IN_RANGE: assert property (running_out |-> io_rdata_out >= `IWDT_CODE_MIN // RL2
      && io_rdata_out <= `IWDT_CODE_MAX)
      else $error("running count left the accepted code range");

   AST_OFF_READS_ZERO: assert property (!running_out |-> io_rdata_out == `IWDT_COUNT_OFF) // RL4
      else $error("count not zero while the watchdog is off");

   AST_READ_WINS: assert property (hit_rd && hit_wr |=> !running_out) // RL4
      else $error("write beat a read in the same cycle");

   AST_OTHER_ADDR_IGNORED: assert property (running_out && !expiry // RL1
      && io_req_in.addr != `IWDT_PORT_ADDR |=> running_out)
      else $error("access to another address stopped the watchdog");

   // The pulse width is checked step by step, so no long repetition is needed.
   AST_PULSE_LOADS: assert property (expiry |=> st.pulse == 8'(RST_PULSE_CYCLES)) // RL5
      else $error("expiry did not load the reset pulse length");

   AST_PULSE_STEPS: assert property (st.pulse != 8'h00 && !expiry // RL5
      |=> st.pulse == $past(st.pulse) - 8'h01)
      else $error("reset pulse did not count down by one");

   AST_NO_SPURIOUS_RESET: assert property (!sys_rst_out && !expiry |=> !sys_rst_out) // RL5
      else $error("system reset rose without an expiry");

   AST_WRITE_IN_PULSE: assert property (sys_rst_out && arm // RL5
      |=> running_out && sys_rst_out == ($past(st.pulse) > 8'h01))
      else $error("write during the reset pulse did not re-arm cleanly");

   COV_ARM: cover property (arm ##1 running_out);
   COV_REARM_IN_PULSE: cover property (sys_rst_out && arm);
   COV_REFRESH: cover property (running_out && arm);
   COV_EXPIRE: cover property ($rose(sys_rst_out));
   COV_DISABLE: cover property (running_out && hit_rd);

endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* Self-checking bench for the I/O port watchdog, driven through its byte port.
   Assumes the design files are compiled first and iwdt_map.svh is on the include path. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int T = 10;
   localparam int P = 4;
   logic clk_in = 1'h0;
   logic srst_in = 1'h1;
   iwdt_pkg::iwdt_io_req_t req = '0;
   logic [7:0] rdata;
   logic running;
   logic sys_rst;
   int mismatches = 0;
   int checked = 0;
   always #20 clk_in = ~clk_in;
   iwdt_top #(.TICK_CYCLES(T), .RST_PULSE_CYCLES(P)) uut (.clk_in(clk_in), .srst_in(srst_in),
      .io_req_in(req), .io_rdata_out(rdata), .running_out(running), .sys_rst_out(sys_rst));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic st(input logic run, input logic [7:0] cnt, input logic rst);
      chk({7'h00, running}, {7'h00, run});
      chk(rdata, cnt);
      chk({7'h00, sys_rst}, {7'h00, rst});
   endtask
   // One bus cycle; strobes stay up so back-to-back calls assign them only once per step.
   task automatic io(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
      req = '{a, d, w, r};
      @(negedge clk_in);
   endtask
   // Idle wait; it drops the strobes left up by the last bus cycle.
   task automatic cyc(input int n);
      req.wr = 1'h0;
      req.rd = 1'h0;
      repeat (n) @(negedge clk_in);
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (3) @(negedge clk_in);
      srst_in = 1'h0;
      st(1'h0, 8'h00, 1'h0);
      io(16'h0443, 8'h02, 1'h1, 1'h0);
      st(1'h1, 8'h02, 1'h0);
      cyc(T - 1);
      st(1'h1, 8'h02, 1'h0);
      cyc(1);
      st(1'h1, 8'h01, 1'h0);
      cyc(T - 1);
      st(1'h1, 8'h01, 1'h0);
      cyc(1);
      st(1'h0, 8'h00, 1'h1);
      cyc(P - 1);
      st(1'h0, 8'h00, 1'h1);
      cyc(1);
      st(1'h0, 8'h00, 1'h0);
      cyc(2 * T);
      st(1'h0, 8'h00, 1'h0);
      io(16'h0443, 8'h00, 1'h1, 1'h0);
      st(1'h0, 8'h00, 1'h0);
      io(16'h0443, 8'h3f, 1'h1, 1'h0);
      st(1'h0, 8'h00, 1'h0);
      io(16'h0442, 8'h05, 1'h1, 1'h0);
      st(1'h0, 8'h00, 1'h0);
      io(16'h0443, 8'h3e, 1'h1, 1'h0);
      st(1'h1, 8'h3e, 1'h0);
      io(16'h0442, 8'h00, 1'h0, 1'h1);
      st(1'h1, 8'h3e, 1'h0);
      io(16'h0443, 8'h03, 1'h1, 1'h0);
      st(1'h1, 8'h03, 1'h0);
      cyc(T + 2);
      st(1'h1, 8'h02, 1'h0);
      io(16'h0443, 8'h03, 1'h1, 1'h0);
      st(1'h1, 8'h03, 1'h0);
      cyc(T - 1);
      st(1'h1, 8'h03, 1'h0);
      cyc(1);
      st(1'h1, 8'h02, 1'h0);
      chk(rdata, 8'h02);
      io(16'h0443, 8'h00, 1'h0, 1'h1);
      st(1'h0, 8'h00, 1'h0);
      cyc(3 * T);
      st(1'h0, 8'h00, 1'h0);
      io(16'h0443, 8'h05, 1'h1, 1'h0);
      st(1'h1, 8'h05, 1'h0);
      io(16'h0443, 8'h07, 1'h1, 1'h1);
      st(1'h0, 8'h00, 1'h0);
      // Shortest code expires, a write re-arms during the pulse, then reset mid-run.
      io(16'h0443, 8'h01, 1'h1, 1'h0);
      st(1'h1, 8'h01, 1'h0);
      cyc(T);
      st(1'h0, 8'h00, 1'h1);
      io(16'h0443, 8'h04, 1'h1, 1'h0);
      st(1'h1, 8'h04, 1'h1);
      io(16'h0443, 8'h3f, 1'h1, 1'h0);
      st(1'h1, 8'h04, 1'h1);
      srst_in = 1'h1;
      cyc(1);
      srst_in = 1'h0;
      st(1'h0, 8'h00, 1'h0);
      cyc(2);
      final_report();
   end
   // The tests need about 130 cycles, so 1000 leaves ample margin.
   initial begin
      repeat (1000) @(posedge clk_in);
      mismatches++;
      final_report();
   end
endmodule
`default_nettype wire
